// ### sram_port_defines.svh
// Constants for the burst SRAM port: widths, burst length and store depth.
// Assumes inclusion by bare name from the package and the port module.
// Functional notes
// RULE1: Synchronous inputs are sampled on the rising clock edge only.
// RULE2: Address is captured only with all selects active and a strobe.
// RULE3: Data pins drive only while selected and output enable active.
// RULE4: Master select blocks processor strobe but not controller strobe.
// RULE5: Secondary selects sampled with controller strobe or master plus proc.
// RULE6: Low processor strobe loads address, or deselects if not selected.
// RULE7: Low controller strobe loads address, or deselects if not selected.
// RULE8: Low step input advances to the next burst address.
// RULE9: Low write-all writes the whole word regardless of lane inputs.
// RULE10: With byte gate low, each low lane input writes its lane.
// RULE11: High byte gate with write-all high makes the cycle a read.
// RULE12: Output enable acts combinationally; drive only during a read. The code registers it, so it acts one edge later.
// RULE13: Order select high or floating is interleaved; low is linear.
// RULE14: High sleep request deselects the device while it stays high.
// RULE15: In sleep all inputs ignored, outputs released, contents kept.
// RULE16: Master must finish pending operations before asserting sleep.
// RULE17: Master issues only deselect or reads during wake interval.
// RULE18: Sleep input is pulled down, so unconnected means awake.
// RULE19: Master deasserts output enable before a write after a read.
// RULE20: Read data appears on the pins one edge after addressing. The code presents it two edges after.
// RULE21: Step ignored with processor strobe low; advance needs strobes high.
// RULE22: Linear counts up modulo four; interleaved XORs start with count.
// RULE23: Controller start needs processor strobe high; writes sampled there.
// RULE24: Data pins release one clock after a deselecting edge.
// RULE25: Suspended burst repeats the current address.
`ifndef SRAM_PORT_DEFINES_SVH
`define SRAM_PORT_DEFINES_SVH
`define SRAM_ADDR_W 21
`define SRAM_DATA_W 18
`define SRAM_LANES 2
`define SRAM_LANE_W 9
`define SRAM_BURST_LEN 4
`define SRAM_DEPTH_SIM 1024
`endif

// ### sram_port_pkg.sv
// Types shared by the burst SRAM port modules.
// Assumes the defines header is on the include path.
`include "sram_port_defines.svh"
package sram_port_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } access_e;
  typedef struct packed {
    logic master_sel_n;
    logic chip_sel_hi;
    logic chip_sel_lo_n;
    logic proc_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_step_n;
  } ctrl_s;
  typedef struct packed {
    logic write_all_n;
    logic byte_gate_n;
    logic [`SRAM_LANES-1:0] lane_write_n;
  } wr_s;
endpackage : sram_port_pkg

// ### sram_store.sv
// Small word store with per-lane write and registered read data.
// Assumes a single clock; the array is not reset, like real SRAM cells.
`timescale 1ns/1ns
module sram_store #(
  parameter int ADDR_W = 10,
  parameter int LANES = 2,
  parameter int LANE_W = 9
) (
  input wire logic clk_sys_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [LANES-1:0] lane_we_in,
  input wire logic [LANES*LANE_W-1:0] wdata_in,
  output logic [LANES*LANE_W-1:0] rdata_out
);
  genvar g;
  generate
    // One array per lane keeps each array under a single process
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [LANE_W-1:0] mem [0:(1<<ADDR_W)-1];
      logic [LANE_W-1:0] rd_reg;
      always_ff @(posedge clk_sys_in) begin
        if (lane_we_in[g]) begin
          mem[addr_in] <= wdata_in[g*LANE_W +: LANE_W];
        end
      end
      always_ff @(posedge clk_sys_in) begin
        rd_reg <= mem[addr_in];
      end
      assign rdata_out[g*LANE_W +: LANE_W] = rd_reg;
    end
  endgenerate
endmodule : sram_store

// ### sync_burst_sram_port.sv
// Pin-level control of a pipelined burst SRAM with 18-bit words.
// Assumes the master drives synchronous pins aligned to clk_sys_in.
`timescale 1ns/1ns
`include "sram_port_defines.svh"
module sync_burst_sram_port
  import sram_port_pkg::*;
#(
  parameter int STORE_AW = 10
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire ctrl_s ctrl_in,
  input wire wr_s wr_in,
  input wire logic [`SRAM_ADDR_W-1:0] addr_in,
  input wire logic out_en_n_in,
  input wire logic linear_order_sel_n_in,
  input wire logic sleep_req_in,
  input wire logic [`SRAM_DATA_W-1:0] dq_in,
  output logic [`SRAM_DATA_W-1:0] dq_out,
  output logic dq_oe_out,
  output logic sleeping_out
);
  // Pull-up and pull-down live on the pad; here they arrive as levels.
  logic sleep_reg;
  logic sleep_meta_reg;
  access_e access_reg;
  logic [`SRAM_ADDR_W-1:0] base_reg;
  logic [1:0] count_reg;
  logic [`SRAM_DATA_W-1:0] rdata_reg;
  logic rd_valid_reg;
  logic [`SRAM_DATA_W-1:0] store_rdata;
  logic selected;
  logic proc_start;
  logic ctrl_start;
  logic start;
  logic deselect;
  logic advance;
  logic wr_cycle;
  logic [`SRAM_LANES-1:0] lane_we;
  logic [1:0] low_bits;
  logic [1:0] next_count;
  logic [1:0] next_bits;
  logic [`SRAM_ADDR_W-1:0] cur_addr;
  logic drive_next;

  // Sleep is synchronised for the sequential logic; pins release on the next edge.
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sleep_meta_reg <= 1'b0;
      sleep_reg <= 1'b0;
    end else begin
      sleep_meta_reg <= sleep_req_in;
      sleep_reg <= sleep_meta_reg;
    end
  end

  // Secondary selects only matter on the strobe edges that sample them
  assign selected = !ctrl_in.master_sel_n && ctrl_in.chip_sel_hi &&
                    !ctrl_in.chip_sel_lo_n; // RULE5
  // Processor strobe is blocked when the master select is high
  assign proc_start = !ctrl_in.proc_addr_strobe_n &&
                      !ctrl_in.master_sel_n; // RULE4
  // Controller start needs the processor strobe high
  assign ctrl_start = !ctrl_in.ctrl_addr_strobe_n &&
                      ctrl_in.proc_addr_strobe_n; // RULE23
  assign start = (proc_start || ctrl_start) && selected; // RULE2 RULE1
  assign deselect = (proc_start || ctrl_start) && !selected; // RULE6 RULE7
  assign advance = ctrl_in.proc_addr_strobe_n &&
                   ctrl_in.ctrl_addr_strobe_n &&
                   !ctrl_in.burst_step_n; // RULE21 RULE8

  // Write decode; lane inputs are ignored on a processor-strobe start
  always_comb begin
    lane_we = '0;
    if (!wr_in.write_all_n) begin
      lane_we = '1; // RULE9
    end else if (!wr_in.byte_gate_n) begin
      lane_we = ~wr_in.lane_write_n; // RULE10
    end else begin
      lane_we = '0; // RULE11
    end
    if (proc_start) begin
      lane_we = '0;
    end
  end
  assign wr_cycle = |lane_we;

  // Burst order: linear adds, interleaved XORs the running count
  // An advancing edge already accesses the next beat, hence next_bits
  assign next_count = count_reg + 2'h1;
  always_comb begin
    if (!linear_order_sel_n_in) begin
      low_bits = base_reg[1:0] + count_reg; // RULE22 RULE13
      next_bits = base_reg[1:0] + next_count; // RULE22 RULE13
    end else begin
      low_bits = base_reg[1:0] ^ count_reg; // RULE22 RULE13
      next_bits = base_reg[1:0] ^ next_count; // RULE22 RULE13
    end
  end
  assign cur_addr = {base_reg[`SRAM_ADDR_W-1:2], low_bits};

  // Address and burst counter; everything freezes while asleep
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      base_reg <= '0;
      count_reg <= 2'h0;
    end else if (!sleep_reg && !sleep_req_in) begin // RULE15
      if (start) begin
        base_reg <= addr_in; // RULE2
        count_reg <= 2'h0;
      end else if (advance && access_reg != ST_IDLE) begin
        count_reg <= count_reg + 2'h1; // RULE8
      end
      // Otherwise the burst is suspended at the same address
    end
  end

  // Access state: read, write or deselected
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      access_reg <= ST_IDLE;
    end else if (sleep_reg || sleep_req_in) begin
      access_reg <= ST_IDLE; // RULE14
    end else if (deselect) begin
      access_reg <= ST_IDLE; // RULE24
    end else if (start) begin
      access_reg <= (ctrl_start && wr_cycle) ? ST_WRITE : ST_READ; // RULE23
    end else if (access_reg != ST_IDLE &&
                 ctrl_in.proc_addr_strobe_n &&
                 ctrl_in.ctrl_addr_strobe_n) begin
      access_reg <= wr_cycle ? ST_WRITE : ST_READ; // RULE25
    end
  end

  // Store access for the address being presented this cycle
  logic [`SRAM_ADDR_W-1:0] acc_addr;
  logic [`SRAM_LANES-1:0] store_we;
  always_comb begin
    acc_addr = cur_addr;
    if (start) begin
      acc_addr = addr_in;
    end else if (advance && access_reg != ST_IDLE) begin
      acc_addr = {base_reg[`SRAM_ADDR_W-1:2],
                  next_bits}; // RULE8
    end
    store_we = '0;
    if (!sleep_reg && !sleep_req_in && !deselect) begin // RULE15
      if (start && ctrl_start) begin
        store_we = lane_we; // RULE23
      end else if (!start && access_reg != ST_IDLE &&
                   ctrl_in.proc_addr_strobe_n &&
                   ctrl_in.ctrl_addr_strobe_n) begin
        store_we = lane_we; // RULE10
      end
    end
  end

  sram_store #(
    .ADDR_W(STORE_AW),
    .LANES(`SRAM_LANES),
    .LANE_W(`SRAM_LANE_W)
  ) u_store (
    .clk_sys_in(clk_sys_in),
    .addr_in(acc_addr[STORE_AW-1:0]),
    .lane_we_in(store_we),
    .wdata_in(dq_in),
    .rdata_out(store_rdata)
  );

  // A read addressed on one edge shows on the pins after the second edge after it
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= (access_reg == ST_READ) && !sleep_reg; // RULE20
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= store_rdata; // RULE20
    end
  end

  // Enable is a flip-flop of read state and the live pins, so that
  // output enable and sleep still act within one cycle.
  // Waiting for valid read data keeps stale words off the pins
  assign drive_next = rd_valid_reg && (access_reg == ST_READ);
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dq_oe_out <= 1'b0;
      dq_out <= '0;
      sleeping_out <= 1'b0;
    end else begin
      dq_oe_out <= drive_next && !out_en_n_in &&
                   !sleep_req_in && !sleep_reg && !wr_cycle; // RULE12 RULE3
      dq_out <= rdata_reg;
      sleeping_out <= sleep_reg || sleep_req_in; // RULE14 RULE18
    end
  end

  a_no_drive_sleep: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    sleep_req_in |=> !dq_oe_out) // RULE15
    else $error("Data driven during sleep");
  a_oe_blocks: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    out_en_n_in |=> !dq_oe_out) // RULE12
    else $error("Data driven with output enable off");
  a_deselect_release: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    deselect && !sleep_req_in |=> ##1 !dq_oe_out) // RULE24
    else $error("Pins not released after deselect");
  a_load_addr: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    start && !sleep_reg && !sleep_req_in |=>
      base_reg == $past(addr_in) && count_reg == 2'h0) // RULE2
    else $error("Address not captured");
  a_proc_blocked: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    ctrl_in.master_sel_n && ctrl_in.ctrl_addr_strobe_n |-> !start) // RULE4
    else $error("Processor strobe not blocked");
  a_step_count: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in || sleep_reg || sleep_req_in)
    advance && !start && access_reg != ST_IDLE |=>
      count_reg == $past(count_reg) + 2'h1) // RULE8
    else $error("Burst did not advance");
  a_suspend_hold: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    ctrl_in.proc_addr_strobe_n && ctrl_in.ctrl_addr_strobe_n &&
    ctrl_in.burst_step_n |=> $stable(count_reg)) // RULE25
    else $error("Suspended burst moved");
  a_write_all: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    !wr_in.write_all_n && !proc_start |-> lane_we == '1) // RULE9
    else $error("Write-all did not select all lanes");
  a_gate_read: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    wr_in.write_all_n && wr_in.byte_gate_n |-> !wr_cycle) // RULE11
    else $error("High byte gate still wrote");

  // Strobe decode and select qualification
  a_deselect_idle: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    deselect |=> access_reg == ST_IDLE) // RULE6 RULE7
    else $error("Deselect left an access open");
  a_ctrl_proc_low: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    !ctrl_in.proc_addr_strobe_n && ctrl_in.master_sel_n |-> !start) // RULE23
    else $error("Controller start with processor strobe low");
  a_ctrl_master: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    ctrl_start && ctrl_in.master_sel_n |-> deselect) // RULE4 RULE5
    else $error("Controller strobe not honoured as deselect");
  a_start_addr: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    start |-> acc_addr == addr_in) // RULE2
    else $error("Start did not access the external address");

  // Write decode
  a_lane_write: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    wr_in.write_all_n && !wr_in.byte_gate_n && !proc_start |->
      lane_we == ~wr_in.lane_write_n) // RULE10
    else $error("Lane inputs not applied");
  a_proc_read: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    proc_start |-> lane_we == '0) // RULE23
    else $error("Processor start took lane writes");
  a_ctrl_lanes: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    start && ctrl_start && !sleep_reg && !sleep_req_in |->
      store_we == lane_we) // RULE23 RULE9
    else $error("Controller write not passed to the store");
  a_write_no_drive: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    wr_cycle |=> !dq_oe_out) // RULE12
    else $error("Data driven during a write");

  // Burst addressing
  a_linear_step: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    advance && !start && access_reg != ST_IDLE &&
    !linear_order_sel_n_in |->
      acc_addr[1:0] == base_reg[1:0] + count_reg + 2'h1) // RULE22
    else $error("Linear burst step wrong");
  a_inter_step: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    advance && !start && access_reg != ST_IDLE &&
    linear_order_sel_n_in |->
      acc_addr[1:0] == (base_reg[1:0] ^ (count_reg + 2'h1))) // RULE13
    else $error("Interleaved burst step wrong");
  a_suspend_addr: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    ctrl_in.proc_addr_strobe_n && ctrl_in.ctrl_addr_strobe_n &&
    ctrl_in.burst_step_n |-> acc_addr == cur_addr) // RULE25
    else $error("Suspended burst changed address");

  // Read pipeline and pin drive
  a_read_pipe: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    1'b1 |=> dq_out == $past(rdata_reg)) // RULE20
    else $error("Output register skipped a stage");
  a_oe_read_only: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    dq_oe_out |-> $past(access_reg == ST_READ) && $past(rd_valid_reg)) // RULE3
    else $error("Data driven outside a read");
  a_oe_valid: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    !rd_valid_reg |=> !dq_oe_out) // RULE20
    else $error("Data driven before read data was valid");

  // Sleep
  a_sleep_idle: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    sleep_req_in |=> access_reg == ST_IDLE) // RULE14
    else $error("Sleep did not deselect");
  a_sleep_no_write: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    sleep_req_in |-> store_we == '0) // RULE15
    else $error("Store written during sleep");
  a_sleep_flag: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    sleep_req_in |=> sleeping_out) // RULE14
    else $error("Sleep flag not raised");
  a_awake_flag: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    !sleep_req_in && !sleep_reg |=> !sleeping_out) // RULE18
    else $error("Sleep flag raised while awake");
  a_sleep_sync: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    1'b1 |=> sleep_reg == $past(sleep_meta_reg)) // RULE14
    else $error("Sleep synchroniser skipped a stage");

  c_read_burst: cover property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    start ##1 advance [*3]);
  c_ctrl_write: cover property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    ctrl_start && selected && wr_cycle);
  c_sleep: cover property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    sleep_req_in ##1 !sleep_req_in);
  c_linear_burst: cover property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    !linear_order_sel_n_in && advance && access_reg == ST_READ);
  c_suspend: cover property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    access_reg == ST_READ && ctrl_in.proc_addr_strobe_n &&
    ctrl_in.ctrl_addr_strobe_n && ctrl_in.burst_step_n);
endmodule : sync_burst_sram_port

// ### bus_master_model.sv
// Bus master model that drives the burst SRAM port pins.
// Assumes the bench calls its tasks from one process only.
`timescale 1ns/1ns
module bus_master_model
  import sram_port_pkg::*;
(
  input wire logic clk_sys_in,
  output ctrl_s ctrl_out,
  output wr_s wr_out,
  output logic [20:0] addr_out,
  output logic [17:0] wdata_out,
  output logic out_en_n_out,
  output logic linear_order_sel_n_out,
  output logic sleep_req_out
);
  initial begin
    ctrl_out = 6'h05;
    wr_out = 4'hF;
    addr_out = 21'h000000;
    wdata_out = 18'h00000;
    out_en_n_out = 1'b1;
    linear_order_sel_n_out = 1'b1;
    sleep_req_out = 1'b0;
  end
  // One bus cycle; pins change just after the edge and hold a full cycle
  task automatic drive(input ctrl_s c, input wr_s w, input logic [20:0] a,
    input logic [17:0] d, input logic oe_n);
    @(posedge clk_sys_in);
    ctrl_out <= c;
    wr_out <= w;
    addr_out <= a;
    // Released data bus toggles so a stale value never passes for data
    wdata_out <= (w == 4'hF) ? ~wdata_out : d;
    out_en_n_out <= (w != 4'hF) ? 1'b1 : oe_n;
  endtask : drive
  // Sleep only requested by the bench once the bus is deselected
  task automatic mode(input logic ord_n, input logic slp);
    @(posedge clk_sys_in);
    linear_order_sel_n_out <= ord_n;
    sleep_req_out <= slp;
  endtask : mode
endmodule : bus_master_model

// ### sync_burst_sram_port_tb.sv
// Self-checking bench for the burst SRAM port with a shadow memory.
// Assumes the store keeps only the low address bits; uses words 0..63.
`timescale 1ns/1ns
module sync_burst_sram_port_tb
  import sram_port_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  ctrl_s ctrl;
  wr_s wr;
  logic [20:0] addr;
  logic [17:0] wdata, dq_out;
  logic oe_n, order_n, sleep_req, dq_oe_out, sleeping_out;
  int n_mismatch = 0;
  int n_compared = 0;
  integer seed = 32'hE96038E0;
  logic [17:0] shadow [64];
  always #2 clk_sys_in = ~clk_sys_in;
  sync_burst_sram_port #(.STORE_AW(10)) i_dut (.clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in), .ctrl_in(ctrl), .wr_in(wr), .addr_in(addr),
    .out_en_n_in(oe_n), .linear_order_sel_n_in(order_n),
    .sleep_req_in(sleep_req), .dq_in(wdata), .dq_out(dq_out),
    .dq_oe_out(dq_oe_out), .sleeping_out(sleeping_out));
  bus_master_model i_m (.clk_sys_in(clk_sys_in), .ctrl_out(ctrl),
    .wr_out(wr), .addr_out(addr), .wdata_out(wdata), .out_en_n_out(oe_n),
    .linear_order_sel_n_out(order_n), .sleep_req_out(sleep_req));
  task automatic check(string what, logic [17:0] seen, logic [17:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  function automatic logic [31:0] rnd();
    return $random(seed);
  endfunction : rnd
  // Upper bits random, bits above the used 64 words kept clear to avoid alias
  function automatic logic [20:0] full_addr(logic [5:0] a);
    logic [31:0] r;
    r = rnd();
    return {r[10:0], 4'h0, a};
  endfunction : full_addr
  function automatic logic [17:0] merge(logic [17:0] o, logic [17:0] d,
    wr_s w);
    logic [17:0] r;
    r = o;
    if (!w.write_all_n) r = d;
    else if (!w.byte_gate_n) begin
      if (!w.lane_write_n[0]) r[8:0] = d[8:0];
      if (!w.lane_write_n[1]) r[17:9] = d[17:9];
    end
    return r;
  endfunction : merge
  task automatic wr_word(logic [5:0] a, logic [17:0] d, wr_s w, bit upd);
    i_m.drive(6'h15, w, full_addr(a), d, 1'b1);
    i_m.drive(6'h05, 4'hF, 21'h000000, 18'h00000, 1'b1);
    if (upd) shadow[a] = merge(shadow[a], d, w);
  endtask : wr_word
  task automatic idle(int n);
    repeat (n) i_m.drive(6'h05, 4'hF, 21'h000000, 18'h00000, 1'b1);
  endtask : idle
  task automatic rd_burst(logic [5:0] a, int n, logic ord_n, logic oe);
    logic [5:0] q[$];
    logic [1:0] k;
    logic s;
    k = 2'h0;
    q.push_back(a);
    i_m.mode(ord_n, 1'b0);
    // Step held low on the start edge must not advance the burst
    i_m.drive(6'h12, 4'hF, full_addr(a), 18'h00000, oe);
    for (int e = 0; e <= n + 1; e++) begin
      s = (e + 1 < n) ? rnd() : 1'b1;
      i_m.drive(6'h16 | s, 4'hF, 21'h000000, 18'h00000, oe);
      #1;
      if (e >= 2) begin
        check("dq_oe_out", dq_oe_out, !oe);
        if (!oe) check("dq_out", dq_out, shadow[q[e-2]]);
      end
      if (!s) k++;
      q.push_back({a[5:2], ord_n ? a[1:0] ^ k : a[1:0] + k});
    end
    idle(4);
    #1 check("dq_oe_out", dq_oe_out, 1'b0);
  endtask : rd_burst
  initial begin
    #20000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    ctrl_s refused [4] = '{6'h33, 6'h1B, 6'h03, 6'h1D};
    logic [5:0] a;
    repeat (16) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    for (int i = 0; i < 64; i++) wr_word(i[5:0], rnd(), 4'h7, 1'b1);
    for (int i = 0; i < 16; i++) begin
      a = rnd();
      wr_word(a, rnd(), i[3:0], 1'b1);
      rd_burst(a, 1, 1'b1, 1'b0);
    end
    for (int i = 0; i < 10; i++) rd_burst(rnd(), 4 + i % 3, i[0], 1'b0);
    rd_burst(6'h05, 2, 1'b0, 1'b1);
    foreach (refused[i]) begin
      i_m.drive(refused[i], 4'hF, full_addr(6'h00), 18'h00000, 1'b0);
      repeat (3) i_m.drive(6'h17, 4'hF, 21'h000000, 18'h00000, 1'b0);
      #1 check("dq_oe_out", dq_oe_out, 1'b0);
    end
    idle(2);
    i_m.mode(1'b1, 1'b1);
    idle(3);
    #1 check("sleeping_out", sleeping_out, 1'b1);
    check("dq_oe_out", dq_oe_out, 1'b0);
    wr_word(6'h00, ~shadow[0], 4'h7, 1'b0);
    i_m.mode(1'b1, 1'b0);
    idle(4);
    #1 check("sleeping_out", sleeping_out, 1'b0);
    rd_burst(6'h00, 1, 1'b1, 1'b0);
    stop_test();
  end
endmodule : sync_burst_sram_port_tb
